// [logic/grf_pkg.sv]
// Purpose: constants and types shared by the gamma reference bus front end
// Assumes: 250 MHz system clock, 10-bit channel codes
// Notes:   times are kept in ns; cycle counts derive from them
package grf_pkg;

  localparam int CLK_PERIOD_NS = 4;

  // bus address: six fixed upper bits, lsb from the address-select pin
  localparam logic [5:0] DEV_ADDR_HI  = 6'h3a;
  localparam logic [7:0] GC_ADDR      = 8'h00;
  localparam logic [7:0] GC_RESET     = 8'h06;
  localparam logic [4:0] HS_CODE_HI   = 5'h01;
  localparam logic [3:0] BYTE_BITS    = 4'h8;

  // channel layout: eight gamma channels then the common-voltage channel
  localparam int         CODE_W       = 10;
  localparam int         GAMMA_CH     = 8;
  localparam int         NUM_CH       = 9;
  localparam int         NUM_BANK     = 2;
  localparam logic [3:0] COMMON_IDX   = 4'h8;
  localparam logic [4:0] LAST_WORD    = 5'h11;
  localparam logic [9:0] MIDSCALE     = 10'h200;

  // power-on load time of both banks
  localparam int LOAD_TIME_NS   = 560000;
  localparam int LOAD_CYCLES    = LOAD_TIME_NS / CLK_PERIOD_NS;
  localparam int LOAD_CNT_W     = 18;

  // endurance of each nonvolatile word
  localparam logic [4:0] NVM_MAX_WRITES = 5'h10;

  typedef enum logic [2:0] {
    BUS_IDLE,
    BUS_ADDR,
    BUS_ADDR_ACK,
    BUS_WDATA,
    BUS_WDATA_ACK,
    BUS_GC_DATA,
    BUS_GC_ACK,
    BUS_IGNORE
  } grf_bus_e;

  typedef enum logic [1:0] {
    LD_MID,
    LD_READ,
    LD_WAIT,
    LD_RUN
  } grf_load_e;

  typedef logic [NUM_CH-1:0][CODE_W-1:0] grf_bank_t;

endpackage

// [logic/grf_i2c_slave_frontend.sv]
// Purpose: two-wire slave front end and power-on bank load of a gamma
//          and common-voltage reference
// Assumes: scl/sda and the strap pins are asynchronous to clk_sys_i;
//          the nonvolatile array answers a read one cycle later
// Notes:   write/update protocol and acquire commands are not handled
`timescale 1ns/1ns
`default_nettype none

module grf_i2c_slave_frontend #(
  parameter int LOAD_CYCLES = grf_pkg::LOAD_CYCLES
) (
  input  wire logic                                         clk_sys_i,
  input  wire logic                                         reset_n_i,
  // two-wire pins; the clock has no output of its own
  input  wire logic                                         scl_i,
  input  wire logic                                         sda_i,
  output logic                                              sda_o,
  output logic                                              sda_oe_o,
  // strap pins, asynchronous
  input  wire logic                                         addr_select_pin_i,
  input  wire logic                                         bank_select_pin_i,
  // nonvolatile array
  output logic                                              nvm_rd_o,
  output logic [4:0]                                        nvm_addr_o,
  input  wire logic [grf_pkg::CODE_W-1:0]                   nvm_data_i,
  input  wire logic                                         nvm_wr_req_i,
  input  wire logic [4:0]                                   nvm_wr_count_i,
  output logic                                              nvm_wr_grant_o,
  // channel codes and status
  output logic [grf_pkg::GAMMA_CH-1:0][grf_pkg::CODE_W-1:0] gamma_channel_outputs_o,
  output logic [grf_pkg::CODE_W-1:0]                        common_voltage_output_o,
  output logic                                              hs_mode_o,
  output logic                                              load_done_o
);
  import grf_pkg::*;

  typedef struct packed {
    // pin samplers and edge detection
    logic [1:0]            scl_sync;
    logic                  scl_d;
    logic [1:0]            sda_sync;
    logic                  sda_d;
    logic [1:0]            addr_sel_sync;
    logic [1:0]            bank_sync;
    logic                  bank_d;
    // byte engine
    grf_bus_e              bus;
    logic [3:0]            bit_cnt;
    logic [7:0]            shreg;
    logic                  ack_drive;
    logic                  hs_mode;
    // power-on load
    grf_load_e             load;
    logic [LOAD_CNT_W-1:0] load_cnt;
    logic [4:0]            rd_idx;
    logic                  cap_pend;
    logic [4:0]            cap_idx;
    // one storage set per bank, plus the codes shown at the outputs
    grf_bank_t [NUM_BANK-1:0] store;
    grf_bank_t             dac;
  } grf_state_s;

  grf_state_s s;
  grf_state_s next_s;

  // flat word index 0..17 -> bank (0: first nine words) and channel
  function automatic logic word_bank(input logic [4:0] idx);
    word_bank = (idx > {1'b0, COMMON_IDX});
  endfunction

  function automatic logic [3:0] word_chan(input logic [4:0] idx);
    logic [4:0] ch;
    ch = word_bank(idx) ? idx - 5'(NUM_CH) : idx;
    word_chan = ch[3:0];
  endfunction

  // data bits are taken only in the three byte states; the ninth clock
  // of a byte belongs to the acknowledge and must not shift or count
  function automatic logic takes_bits(input grf_bus_e st);
    takes_bits = (st == BUS_ADDR) || (st == BUS_WDATA) ||
                 (st == BUS_GC_DATA);
  endfunction

  // the general-call address is decoded in two states
  function automatic logic is_gc_addr(input logic [7:0] b);
    is_gc_addr = (b == GC_ADDR);
  endfunction

  // master code: upper five bits fixed, lower three belong to the master
  function automatic logic is_hs_code(input logic [7:0] b);
    is_hs_code = (b[7:3] == HS_CODE_HI);
  endfunction

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic bank_sel;
  logic byte_done;
  logic own_addr;
  logic soft_reset;
  logic [LOAD_CNT_W-1:0] load_limit;

  assign scl        = s.scl_sync[1];
  assign sda        = s.sda_sync[1];
  assign bank_sel   = s.bank_sync[1];
  assign scl_rise   = scl & ~s.scl_d;
  assign scl_fall   = ~scl & s.scl_d;
  // both conditions need the clock high in this and the last sample, so
  // a data change just after a clock fall is never taken for either
  assign start_cond = scl & s.scl_d & s.sda_d & ~sda;
  assign stop_cond  = scl & s.scl_d & ~s.sda_d & sda;
  assign byte_done  = scl_fall && (s.bit_cnt == BYTE_BITS);
  // the strap goes through its own synchroniser, so it may change
  // between frames but should not move during an address byte
  assign own_addr   = (s.shreg[7:1] ==
                       {DEV_ADDR_HI, s.addr_sel_sync[1]});
  assign load_limit = LOAD_CNT_W'(LOAD_CYCLES);

  // one pass: samplers, byte engine, start and stop override, then the
  // power-on sequence; a general-call reset comes last so that it wins
  // over everything else decided in the same cycle except an update of the output codes or a word captured into storage
  always_comb begin
    next_s     = s;
    soft_reset = 1'b0;

    // two-flop synchronisers; the logic reads only the second stage
    next_s.scl_sync  = {s.scl_sync[0], scl_i};
    next_s.sda_sync  = {s.sda_sync[0], sda_i};
    next_s.addr_sel_sync = {s.addr_sel_sync[0], addr_select_pin_i};
    next_s.bank_sync = {s.bank_sync[0], bank_select_pin_i};
    next_s.scl_d     = scl;
    next_s.sda_d     = sda;
    next_s.bank_d    = bank_sel;

    if (scl_rise && takes_bits(s.bus) && s.bit_cnt != BYTE_BITS) begin
      next_s.shreg   = {s.shreg[6:0], sda};
      next_s.bit_cnt = s.bit_cnt + 4'h1;
    end

    case (s.bus)
      BUS_ADDR: begin
        if (byte_done) begin
          next_s.bit_cnt = '0;
          if (own_addr && !s.shreg[0]) begin
            next_s.ack_drive = 1'b1;
            next_s.bus       = BUS_ADDR_ACK;
          end else if (own_addr) begin
            // reads are acknowledged but return released ones
            next_s.ack_drive = 1'b1;
            next_s.bus       = BUS_ADDR_ACK;
          end else if (is_gc_addr(s.shreg)) begin
            next_s.ack_drive = 1'b1;
            next_s.bus       = BUS_ADDR_ACK;
          end else if (is_hs_code(s.shreg)) begin
            // no acknowledge: the data line stays released for clock nine
            next_s.hs_mode = 1'b1;
            next_s.bus     = BUS_IGNORE;
          end else begin
            next_s.bus = BUS_IGNORE;
          end
        end
      end
      BUS_ADDR_ACK: begin
        if (scl_fall) begin
          next_s.ack_drive = 1'b0;
          next_s.bit_cnt   = '0;
          if (is_gc_addr(s.shreg)) begin
            next_s.bus = BUS_GC_DATA;
          end else if (s.shreg[0]) begin
            next_s.bus = BUS_IGNORE;
          end else begin
            next_s.bus = BUS_WDATA;
          end
        end
      end
      BUS_WDATA: begin
        if (byte_done) begin
          next_s.bit_cnt   = '0;
          next_s.ack_drive = 1'b1;
          next_s.bus       = BUS_WDATA_ACK;
        end
      end
      BUS_WDATA_ACK: begin
        if (scl_fall) begin
          next_s.ack_drive = 1'b0;
          next_s.bit_cnt   = '0;
          next_s.bus       = BUS_WDATA;
        end
      end
      BUS_GC_DATA: begin
        if (byte_done) begin
          next_s.bit_cnt = '0;
          if (s.shreg == GC_RESET) begin
            next_s.ack_drive = 1'b1;
            next_s.bus       = BUS_GC_ACK;
          end else begin
            next_s.bus = BUS_IGNORE;
          end
        end
      end
      BUS_GC_ACK: begin
        if (scl_fall) begin
          // reset waits for the ack to be released so the bus is clean
          soft_reset = 1'b1;
        end
      end
      default: begin
      end
    endcase

    // a stop or start overrides whatever byte is in progress
    if (stop_cond) begin
      next_s.bus       = BUS_IDLE;
      next_s.ack_drive = 1'b0;
      next_s.hs_mode   = 1'b0;
    end else if (start_cond) begin
      // repeated start keeps high speed untouched
      next_s.bus       = BUS_ADDR;
      next_s.bit_cnt   = '0;
      next_s.ack_drive = 1'b0;
    end

    // power-on sequence
    next_s.cap_pend = 1'b0;
    if (s.cap_pend) begin
      next_s.store[word_bank(s.cap_idx)][word_chan(s.cap_idx)] =
        nvm_data_i;
    end
    case (s.load)
      LD_MID: begin
        for (int i = 0; i < NUM_CH; i++) begin
          next_s.dac[i] = MIDSCALE;
        end
        next_s.load_cnt = '0;
        next_s.rd_idx   = '0;
        next_s.load     = LD_READ;
      end
      LD_READ: begin
        // both banks are fetched, one word per cycle
        next_s.cap_pend = 1'b1;
        next_s.cap_idx  = s.rd_idx;
        next_s.rd_idx   = s.rd_idx + 5'h1;
        next_s.load_cnt = s.load_cnt + 1'b1;
        if (s.rd_idx == LAST_WORD) begin
          next_s.load = LD_WAIT;
        end
      end
      LD_WAIT: begin
        // hold the outputs at midscale for the full load time; a bank pin
        // change meanwhile is not replayed, the end picks the bank then
        next_s.load_cnt = s.load_cnt + 1'b1;
        // wait for the last captured word so a short load time cannot
        // apply a bank with one word still missing
        if (!s.cap_pend && s.load_cnt >= load_limit - 1'b1) begin
          next_s.dac  = s.store[bank_sel];
          next_s.load = LD_RUN;
        end
      end
      LD_RUN: begin
        if (bank_sel != s.bank_d) begin
          // no memory read, so the switch is a single cycle
          next_s.dac = s.store[bank_sel];
        end
      end
      default: begin
        next_s.load = LD_MID;
      end
    endcase

    // the general-call reset restarts the load; storage keeps its words
    // until the new load overwrites them
    if (soft_reset) begin
      next_s.bus       = BUS_IDLE;
      next_s.bit_cnt   = '0;
      next_s.ack_drive = 1'b0;
      next_s.hs_mode   = 1'b0;
      next_s.load      = LD_MID;
      next_s.cap_pend  = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      // the bus pins idle high; starting the samplers high keeps the
      // first edges after reset from looking like a clock or data edge
      s          <= '0;
      s.scl_sync <= '1;
      s.scl_d    <= 1'b1;
      s.sda_sync <= '1;
      s.sda_d    <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // open-drain data: low when driven; the clock pin has no output at all
  assign sda_o    = 1'b0;
  assign sda_oe_o = s.ack_drive;

  // one word per cycle: the address leads the captured data by one cycle
  assign nvm_rd_o   = (s.load == LD_READ);
  assign nvm_addr_o = s.rd_idx;

  // endurance guard: a write to a word is only let through below 16
  // the tally itself lives in the array; this block keeps none
  assign nvm_wr_grant_o = nvm_wr_req_i &&
                          (nvm_wr_count_i < NVM_MAX_WRITES);

  assign gamma_channel_outputs_o = s.dac[GAMMA_CH-1:0];
  assign common_voltage_output_o = s.dac[COMMON_IDX];
  // standard and fast need no mode flag; filters follow this bit
  assign hs_mode_o   = s.hs_mode;
  assign load_done_o = (s.load == LD_RUN);

endmodule

`default_nettype wire

// [verification/grf_frontend_checker.sv]
// Purpose: port-level checks on the gamma reference bus front end
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   scl is assumed low for at least five clocks in each bit
`timescale 1ns/1ns
`default_nettype none
module grf_frontend_checker
  import grf_pkg::*;
#(
  parameter int LOAD_CYCLES = 40
) (
  input wire logic                             clk_sys_i,
  input wire logic                             reset_n_i,
  input wire logic                             scl_i,
  input wire logic                             sda_i,
  input wire logic                             sda_o,
  input wire logic                             sda_oe_o,
  input wire logic                             nvm_rd_o,
  input wire logic [4:0]                       nvm_addr_o,
  input wire logic                             nvm_wr_req_i,
  input wire logic [4:0]                       nvm_wr_count_i,
  input wire logic                             nvm_wr_grant_o,
  input wire logic [GAMMA_CH-1:0][CODE_W-1:0]  gamma_channel_outputs_o,
  input wire logic [CODE_W-1:0]                common_voltage_output_o,
  input wire logic                             hs_mode_o,
  input wire logic                             load_done_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  sda_low_a: assert property (sda_o == 1'b0)
    else $error("data pin value not low");
  grant_limit_a: assert property (nvm_wr_grant_o ==
    (nvm_wr_req_i && nvm_wr_count_i < 5'h10)) else $error("grant wrong");
  mid_first_a: assert property (nvm_rd_o |->
    gamma_channel_outputs_o == {GAMMA_CH{MIDSCALE}} &&
    common_voltage_output_o == MIDSCALE) else $error("not midscale");
  rd_not_done_a: assert property (nvm_rd_o |-> !load_done_o)
    else $error("done while loading");
  addr_range_a: assert property (nvm_rd_o |-> nvm_addr_o <= 5'h11)
    else $error("word index out of range");
  load_order_a: assert property ($rose(nvm_rd_o) |->
    nvm_addr_o == 5'h00 ##1 nvm_addr_o == 5'h01) else $error("load order");
  ack_stable_a: assert property (scl_i && $past(scl_i) |->
    $stable(sda_oe_o)) else $error("ack moved while clock high");
  ack_hold_a: assert property ($rose(sda_oe_o) |-> sda_oe_o [*6])
    else $error("ack too short");
  hs_no_ack_a: assert property ($rose(hs_mode_o) |-> !sda_oe_o [*4])
    else $error("master code acked");
  hs_exit_a: assert property (hs_mode_o && scl_i && $rose(sda_i)
    |-> ##[1:8] !hs_mode_o) else $error("high speed kept after stop");

  cover property ($rose(load_done_o));
  cover property ($rose(hs_mode_o));
  cover property ($rose(sda_oe_o));
endmodule

bind grf_i2c_slave_frontend grf_frontend_checker #(
  .LOAD_CYCLES(LOAD_CYCLES)
) i_chk (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .scl_i(scl_i),
  .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .nvm_rd_o(nvm_rd_o),
  .nvm_addr_o(nvm_addr_o), .nvm_wr_req_i(nvm_wr_req_i),
  .nvm_wr_count_i(nvm_wr_count_i), .nvm_wr_grant_o(nvm_wr_grant_o),
  .gamma_channel_outputs_o(gamma_channel_outputs_o),
  .common_voltage_output_o(common_voltage_output_o),
  .hs_mode_o(hs_mode_o), .load_done_o(load_done_o)
);
`default_nettype wire

// [verification/grf_bus_master.sv]
// Purpose: behavioural two-wire bus master facing the front end
// Assumes: line has a pull-up; master only ever pulls data low
// Notes:   bit time 32 ns; clock stands high between frames
`timescale 1ns/1ns
`default_nettype none
module grf_bus_master (
  output var logic scl_o,
  output var logic sda_low_o,
  input  wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // data only moves while the clock is low
  task automatic put_bit(input logic v, output logic s);
    #4 sda_low_o = !v;
    #16 scl_o = 1'b1;
    #6 s = sda_i;
    #6 scl_o = 1'b0;
  endtask
  // also serves as repeated start
  task automatic start_cond();
    #4 sda_low_o = 1'b0;
    #16 scl_o = 1'b1;
    #6 sda_low_o = 1'b1;
    #6 scl_o = 1'b0;
  endtask
  task automatic stop_cond();
    #4 sda_low_o = 1'b1;
    #16 scl_o = 1'b1;
    #6 sda_low_o = 1'b0;
    #6;
  endtask
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) put_bit(b[i], s);
    put_bit(1'b1, s);
    ack = !s;
  endtask
endmodule
`default_nettype wire

// [verification/grf_i2c_slave_frontend_test.sv]
// Purpose: self-checking bench for the bus front end and bank load
// Assumes: nonvolatile array modelled here, answering one cycle late
// Notes:   load time shortened through LOAD_CYCLES
`timescale 1ns/1ns
`default_nettype none
module grf_i2c_slave_frontend_test;
  import grf_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, addr_sel = 1'b0, bank_sel = 1'b0;
  logic wr_req = 1'b0, nvm_rd, grant, oe, sda_val, hs, done, scl, m_low;
  logic [4:0] wr_count = 5'h00, nvm_addr, addr_q = 5'h00;
  logic [9:0] nvm_data = 10'h000, cv_code;
  logic [GAMMA_CH-1:0][CODE_W-1:0] gamma;
  int num_errors = 0, tests_run = 0;
  wire sda_line = !(m_low || (oe && !sda_val));
  always #2 clk = !clk;
  grf_bus_master i_master (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda_line));
  grf_i2c_slave_frontend #(.LOAD_CYCLES(64)) i_dut (.clk_sys_i(clk),
    .reset_n_i(reset_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_val),
    .sda_oe_o(oe), .addr_select_pin_i(addr_sel),
    .bank_select_pin_i(bank_sel), .nvm_rd_o(nvm_rd), .nvm_addr_o(nvm_addr),
    .nvm_data_i(nvm_data), .nvm_wr_req_i(wr_req), .nvm_wr_count_i(wr_count),
    .nvm_wr_grant_o(grant), .gamma_channel_outputs_o(gamma),
    .common_voltage_output_o(cv_code), .hs_mode_o(hs), .load_done_o(done));
  function automatic logic [9:0] word(input int a);
    return 10'h0a5 + 10'(a) * 10'h01d;
  endfunction
  always @(posedge clk) addr_q <= nvm_addr;
  always @(negedge clk) nvm_data <= word(int'(addr_q));
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic codes(input int b);
    for (int c = 0; c < 8; c++) chk(gamma[c], word(b * 9 + c));
    chk(cv_code, word(b * 9 + 8));
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 500) begin
      @(negedge clk);
      n++;
    end
    chk({9'h0, done}, 10'h001);
  endtask
  // address byte or data byte, then compare the acknowledge seen
  task automatic xact(input logic [7:0] b, input logic exp);
    logic a;
    i_master.send_byte(b, a);
    chk({9'h0, a}, {9'h0, exp});
  endtask
  task automatic t_load();
    cycles(3);
    chk(cv_code, MIDSCALE);
    wait_done();
    codes(0);
    bank_sel = 1'b1;
    cycles(6);
    codes(1);
  endtask
  task automatic t_addr();
    logic [6:0] ad;
    for (int a = 0; a < 2; a++) begin
      for (int k = 0; k < 3; k++) begin
        cycles(2);
        addr_sel = a[0];
        ad = (k == 0) ? 7'h74 : (k == 1) ? 7'h75 : 7'h34;
        cycles(4);
        #1;
        i_master.start_cond();
        xact({ad, a[0]}, ad == (7'h74 | 7'(a)));
        i_master.stop_cond();
      end
    end
  endtask
  task automatic t_gc();
    cycles(2);
    #1;
    i_master.start_cond();
    xact(8'h00, 1'b1);
    xact(8'h05, 1'b0);
    i_master.stop_cond();
    i_master.start_cond();
    xact(8'h00, 1'b1);
    xact(8'h06, 1'b1);
    cycles(8);
    chk({9'h0, done}, 10'h000);
    chk(cv_code, MIDSCALE);
    #1;
    i_master.stop_cond();
    wait_done();
    codes(1);
  endtask
  task automatic t_hs();
    for (int k = 0; k < 8; k++) begin
      cycles(2);
      #1;
      i_master.start_cond();
      xact(8'h08 + 8'(k), 1'b0);
      cycles(4);
      chk({9'h0, hs}, 10'h001);
      #1;
      i_master.start_cond();
      xact({7'h75, 1'b0}, 1'b1);
      xact(8'h5a, 1'b1);
      chk({9'h0, hs}, 10'h001);
      i_master.stop_cond();
      cycles(8);
      chk({9'h0, hs}, 10'h000);
    end
  endtask
  task automatic t_grant();
    for (int i = 14; i < 18; i++) begin
      @(negedge clk);
      wr_req = 1'b1;
      wr_count = 5'(i);
      cycles(1);
      chk({9'h0, grant}, {9'h0, i < 16});
    end
    wr_req = 1'b0;
  endtask
  initial begin
    cycles(12);
    reset_n = 1'b1;
    t_load();
    t_addr();
    t_gc();
    t_hs();
    t_grant();
    give_verdict();
  end
  // whole run needs about 12 us
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
endmodule
`default_nettype wire
